// [hw/iaf_pkg.sv]
package iaf_pkg;

    // =========================================================
    // Register map (byte addresses)
    // =========================================================
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_OWN_ADDR = 8'h08;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
    localparam logic [7:0] ADDR_RX_DATA = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;

    // =========================================================
    // Status field positions
    // =========================================================
    localparam int BIT_RXF = 5;
    localparam int BIT_ALO = 2;
    localparam int BIT_AAS = 1;
    localparam int BIT_GC = 0;

    // Control field positions
    localparam int BIT_MST = 0;
    localparam int BIT_TRS = 1;

    // Own-address register: bits 7:1 address, bit 0 format select
    localparam int BIT_FS = 0;

    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] OWN_ADDR_RST = 8'h00;
    localparam logic [7:0] RX_DATA_RST = 8'hff;
    localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
    localparam logic [3:0] FRAME_BITS = 4'h8;

    // Interrupt event bit positions
    localparam int EV_ALO = 0;
    localparam int EV_AAS = 1;
    localparam int EV_GC = 2;
    localparam int EV_RXF = 3;

    // =========================================================
    // Carriers
    // =========================================================
    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic sda;
        logic start;
        logic stop;
    } iaf_line_s;

    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic scl_d;
        logic sda_d;
        iaf_line_s ev;
    } iaf_sync_s;

endpackage

// [hw/iaf_line_sync.sv]
`timescale 1ns/1ps
module iaf_line_sync (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic scl_in,
    input wire logic sda_in,
    output iaf_pkg::iaf_line_s line
);
    iaf_pkg::iaf_sync_s st_r;
    iaf_pkg::iaf_sync_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.scl_sync = {st_r.scl_sync[0], scl_in};
        st_nxt.sda_sync = {st_r.sda_sync[0], sda_in};
        st_nxt.scl_d = st_r.scl_sync[1];
        st_nxt.sda_d = st_r.sda_sync[1];
        st_nxt.ev.sda = st_r.sda_sync[1];
        st_nxt.ev.scl_rise = st_r.scl_sync[1] & ~st_r.scl_d;
        st_nxt.ev.scl_fall = ~st_r.scl_sync[1] & st_r.scl_d;
        // Data edges while the clock line is high
        st_nxt.ev.start = st_r.scl_sync[1] & st_r.scl_d & st_r.sda_d & ~st_r.sda_sync[1];
        st_nxt.ev.stop = st_r.scl_sync[1] & st_r.scl_d & ~st_r.sda_d & st_r.sda_sync[1];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl_d: 1'b1, sda_d: 1'b1,
                      ev: '0};
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign line = st_r.ev;
endmodule

// [hw/iaf_flags.sv]
// Contract
// RULE_01: Master transmit, driven data mismatches pin: lost
// RULE_02: Start seen while master drives high: lost
// RULE_03: Clocked format, last bit while full: overrun
// RULE_04: Write zero after reading one clears lost
// RULE_05: Slave receive, first frame matches address: recognized
// RULE_06: General call in slave receive: recognized
// RULE_07: Write zero after reading one clears recognized
// RULE_08: General call in slave receive sets general-call
// RULE_09: General-call flag only in I2C slave receive
// RULE_10: Write zero after reading one clears general-call
// RULE_11: Byte moved to receive register sets full
// RULE_12: Compare seven address bits with first frame
// RULE_13: Zero without prior one-read, or one: no effect
`timescale 1ns/1ps
module iaf_flags (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_drive,
    output logic irq
);
    // =========================================================
    // State
    // =========================================================
    // Frame position: none, first after a start, later frames
    typedef enum logic [1:0] {FR_IDLE, FR_FIRST, FR_NEXT} iaf_frame_e;

    typedef struct packed {
        logic ph_valid;
        logic ph_write;
        logic [7:0] ph_addr;
        logic [7:0] status;
        logic [7:0] seen_one;
        logic mst;
        logic trs;
        logic [7:0] own_addr;
        logic [3:0] irq_en;
        logic [3:0] irq_stat;
        logic [7:0] rx_data;
        logic [7:0] shift;
        logic [3:0] bit_cnt;
        iaf_frame_e frame;
        logic [31:0] rdata;
        logic irq;
        logic ready;
        logic resp;
    } iaf_state_s;

    iaf_state_s st_r;
    iaf_state_s st_nxt;
    iaf_pkg::iaf_line_s line;

    iaf_line_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .line(line)
    );

    function automatic logic [31:0] read_mux(input iaf_state_s s, input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            iaf_pkg::ADDR_STATUS: d = {24'h00_0000, s.status};
            iaf_pkg::ADDR_CTRL: d = {30'h0000_0000, s.trs, s.mst};
            iaf_pkg::ADDR_OWN_ADDR: d = {24'h00_0000, s.own_addr};
            iaf_pkg::ADDR_IRQ_EN: d = {28'h000_0000, s.irq_en};
            iaf_pkg::ADDR_IRQ_STAT: d = {28'h000_0000, s.irq_stat};
            iaf_pkg::ADDR_RX_DATA: d = {24'h00_0000, s.rx_data};
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    // Clear mask from a status write: zero bits previously read as one
    function automatic logic [7:0] clr_mask(input logic [7:0] seen, input logic [7:0] wd);
        return seen & ~wd; // RULE_13
    endfunction

    // Data phase of a transfer to one register
    function automatic logic ph_hit(input iaf_state_s s, input logic wr, input logic [7:0] a);
        return s.ph_valid & (s.ph_write == wr) & (s.ph_addr == a);
    endfunction

    logic ph_take;
    logic wr_stat;
    logic rd_stat;
    logic clocked_fmt;
    logic slave_rx;
    logic frame_done;
    logic in_frame;
    logic [7:0] rx_byte;
    logic [7:0] set_ev;
    logic [7:0] clr_ev;
    logic [3:0] irq_ev;

    always_comb begin
        st_nxt = st_r;
        ph_take = hsel & hready & htrans[1];
        clocked_fmt = st_r.own_addr[iaf_pkg::BIT_FS];
        slave_rx = ~st_r.mst & ~st_r.trs;
        rx_byte = {st_r.shift[6:0], line.sda};
        in_frame = (st_r.frame != FR_IDLE);
        frame_done = line.scl_rise & in_frame & (st_r.bit_cnt == iaf_pkg::FRAME_BITS - 4'h1);
        set_ev = 8'h00;
        clr_ev = 8'h00;
        wr_stat = ph_hit(st_r, 1'b1, iaf_pkg::ADDR_STATUS);
        rd_stat = ph_hit(st_r, 1'b0, iaf_pkg::ADDR_STATUS);

        // =====================================================
        // Bit framing
        // =====================================================
        if (line.start) begin
            st_nxt.bit_cnt = 4'h0;
            st_nxt.frame = FR_FIRST;
        end else if (line.stop) begin
            // Clocked format ignores stop conditions: keep counting
            case (st_r.frame)
                FR_IDLE: st_nxt.frame = clocked_fmt ? FR_NEXT : FR_IDLE;
                FR_FIRST: st_nxt.frame = clocked_fmt ? FR_FIRST : FR_IDLE;
                FR_NEXT: st_nxt.frame = clocked_fmt ? FR_NEXT : FR_IDLE;
                default: st_nxt.frame = FR_IDLE;
            endcase
        end else if (line.scl_rise && (in_frame || clocked_fmt)) begin
            st_nxt.shift = rx_byte;
            st_nxt.bit_cnt = (st_r.bit_cnt == iaf_pkg::FRAME_BITS - 4'h1) ? 4'h0
                : st_r.bit_cnt + 4'h1;
            case (st_r.frame)
                FR_IDLE: st_nxt.frame = FR_NEXT;
                FR_FIRST: st_nxt.frame = frame_done ? FR_NEXT : FR_FIRST;
                FR_NEXT: st_nxt.frame = FR_NEXT;
                default: st_nxt.frame = FR_IDLE;
            endcase
        end

        if (frame_done) begin
            if (!st_r.trs) begin
                st_nxt.rx_data = rx_byte;
                set_ev[iaf_pkg::BIT_RXF] = 1'b1; // RULE_11
            end
            if (clocked_fmt && st_r.status[iaf_pkg::BIT_RXF]) begin
                set_ev[iaf_pkg::BIT_ALO] = 1'b1; // RULE_03
            end
            if (!clocked_fmt && slave_rx && (st_r.frame == FR_FIRST)) begin
                if (rx_byte[7:1] == st_r.own_addr[7:1]) begin
                    set_ev[iaf_pkg::BIT_AAS] = 1'b1; // RULE_05 RULE_12
                end
                if (rx_byte[7:1] == iaf_pkg::GEN_CALL_ADDR) begin
                    set_ev[iaf_pkg::BIT_AAS] = 1'b1; // RULE_06
                    set_ev[iaf_pkg::BIT_GC] = 1'b1; // RULE_08 RULE_09
                end
            end
        end

        if (!clocked_fmt && st_r.mst && st_r.trs && line.scl_rise && (sda_drive != line.sda)) begin
            set_ev[iaf_pkg::BIT_ALO] = 1'b1; // RULE_01
        end
        if (!clocked_fmt && st_r.mst && sda_drive && line.start) begin
            set_ev[iaf_pkg::BIT_ALO] = 1'b1; // RULE_02
        end

        // =====================================================
        // Bus slave
        // =====================================================
        if (wr_stat) begin
            clr_ev = clr_mask(st_r.seen_one, hwdata[7:0]); // RULE_04 RULE_07 RULE_10
            st_nxt.seen_one = st_r.seen_one & ~clr_ev;
        end
        if (st_r.ph_valid && st_r.ph_write) begin
            case (st_r.ph_addr)
                iaf_pkg::ADDR_CTRL: begin
                    st_nxt.mst = hwdata[iaf_pkg::BIT_MST];
                    st_nxt.trs = hwdata[iaf_pkg::BIT_TRS];
                end
                iaf_pkg::ADDR_OWN_ADDR: st_nxt.own_addr = hwdata[7:0];
                iaf_pkg::ADDR_IRQ_EN: st_nxt.irq_en = hwdata[3:0];
                iaf_pkg::ADDR_IRQ_CLR: st_nxt.irq_stat = st_r.irq_stat & ~hwdata[3:0];
                default: st_nxt.irq_en = st_r.irq_en;
            endcase
        end
        // Only ones actually handed to software count as read
        if (rd_stat) begin
            st_nxt.seen_one = st_r.seen_one | st_r.rdata[7:0];
        end
        if (ph_hit(st_r, 1'b0, iaf_pkg::ADDR_RX_DATA)) begin
            clr_ev[iaf_pkg::BIT_RXF] = 1'b1;
        end

        // Set wins over clear
        st_nxt.status = (st_r.status & ~clr_ev) | set_ev;
        // A flag cleared by other means must be read as one again
        st_nxt.seen_one = st_nxt.seen_one & st_nxt.status; // RULE_13
        irq_ev = {set_ev[iaf_pkg::BIT_RXF], set_ev[iaf_pkg::BIT_GC],
                  set_ev[iaf_pkg::BIT_AAS], set_ev[iaf_pkg::BIT_ALO]};
        st_nxt.irq_stat = st_nxt.irq_stat | irq_ev;
        st_nxt.irq = |(st_nxt.irq_stat & st_r.irq_en);

        st_nxt.ph_valid = ph_take;
        st_nxt.ph_write = hwrite;
        st_nxt.ph_addr = haddr;
        st_nxt.rdata = (ph_take && !hwrite) ? read_mux(st_r, haddr) : 32'h0000_0000;
        st_nxt.ready = 1'b1;
        st_nxt.resp = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
            st_r.status <= iaf_pkg::STATUS_RST;
            st_r.own_addr <= iaf_pkg::OWN_ADDR_RST;
            st_r.rx_data <= iaf_pkg::RX_DATA_RST;
            st_r.ready <= 1'b1;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign hrdata = st_r.rdata;
    assign hreadyout = st_r.ready;
    assign hresp = st_r.resp;
    assign irq = st_r.irq;
endmodule

// [tb/iaf_flags_props.sv]
`timescale 1ns/1ps
module iaf_flags_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic ph_v, ph_w, rd_st;
    logic [7:0] ph_a;
    logic [3:0] en_r;
    logic [2:0] keep_r;
    assign rd_st = ph_v && !ph_w && ph_a == iaf_pkg::ADDR_STATUS;
    // Flags seen set stay set until a zero is written over them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {ph_v, ph_w, ph_a, en_r, keep_r} <= '0;
        end else begin
            ph_v <= hsel && hready && htrans[1];
            ph_w <= hwrite;
            ph_a <= haddr;
            if (ph_v && ph_w && ph_a == iaf_pkg::ADDR_IRQ_EN) begin
                en_r <= hwdata[3:0];
            end
            if (ph_v && ph_a == iaf_pkg::ADDR_STATUS) begin
                keep_r <= ph_w ? keep_r & hwdata[2:0] : hrdata[2:0];
            end
        end
    end
    a_ready_high: assert property (hreadyout) else $error("ready low");
    a_resp_okay: assert property (!hresp) else $error("error response");
    a_rdata_idle: assert property (!ph_v || ph_w |-> hrdata == 32'h0)
        else $error("stray read data");
    a_rdata_upper: assert property (ph_v |-> hrdata[31:8] == 24'h0)
        else $error("upper data bits set");
    a_unmapped_zero: assert property (ph_v && ph_a > iaf_pkg::ADDR_IRQ_STAT |-> hrdata == 32'h0)
        else $error("unmapped read data");
    a_flags_sticky: assert property (rd_st |-> (hrdata[2:0] & keep_r) == keep_r)
        else $error("flag lost without clear");
    a_irq_enabled: assert property (irq |-> (en_r | $past(en_r)) != 4'h0)
        else $error("irq while masked");
    a_irq_raised: assert property (rd_st
        && (en_r & {hrdata[5], hrdata[0], hrdata[1], hrdata[2]}) != 4'h0 |-> ##[0:2] irq)
        else $error("irq missing");
    c_addr: cover property (rd_st && hrdata[1]);
    c_lost: cover property (rd_st && hrdata[2]);
    c_irq: cover property ($rose(irq));
endmodule

bind iaf_flags iaf_flags_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .irq);

// [tb/iaf_bus_model.sv]
`timescale 1ns/1ps
module iaf_bus_model (
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Data falls while the link clock is high
    // Pins move 2 ns after a clock edge, never on it
    task automatic start();
        #2 sda = 1'b1;
        #20 scl = 1'b1;
        #40 sda = 1'b0;
        #40 scl = 1'b0;
        #18;
    endtask
    // Clock parks low after the frame, data released to its pull-up
    task automatic bits(input logic [7:0] b);
        #2;
        for (int i = 7; i >= 0; i--) begin
            sda = b[i];
            #20 scl = 1'b1;
            #40 scl = 1'b0;
            #20;
        end
        sda = 1'b1;
        #8;
    endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, sda_drive, hreadyout, hresp, irq, scl, sda, clk_en;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, q;
    int n_mismatch, tests_run, cyc;
    always #5 hclk = ~hclk;
    iaf_bus_model u_bus (.scl(scl), .sda(sda));
    iaf_flags u_dut (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .scl_in(scl), .sda_in(sda), .sda_drive, .irq);
    task results();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            $display("unexpected %s: expected %h seen %h", n, e, s);
            n_mismatch++;
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
        bus(1'b0, a, 32'h0);
        chk(n, e, q & m);
    endtask
    task settle();
        #100;
        @(posedge hclk);
    endtask
    // Zero before reading is ignored, zero after reading clears, ones never set
    task flow(input logic [2:0] e, input string n);
        repeat (3) @(posedge hclk);
        chk("irq raised", 32'h1, {31'h0, irq});
        bus(1'b1, iaf_pkg::ADDR_STATUS, 32'h0);
        rd(iaf_pkg::ADDR_STATUS, 32'h7, {29'h0, e}, "flags kept");
        bus(1'b1, iaf_pkg::ADDR_STATUS, 32'h0);
        rd(iaf_pkg::ADDR_STATUS, 32'h7, 32'h0, "flags cleared");
        bus(1'b1, iaf_pkg::ADDR_STATUS, 32'hff);
        rd(iaf_pkg::ADDR_STATUS, 32'h7, 32'h0, "flags not set");
        bus(1'b1, iaf_pkg::ADDR_IRQ_CLR, 32'hf);
        repeat (3) @(posedge hclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test %s done", n);
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        {hresetn, hsel, hwrite, sda_drive, haddr, htrans, hsize, hwdata} = '0;
        clk_en = 1'b1;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(iaf_pkg::ADDR_STATUS, 32'hff, 32'h0, "status reset");
        rd(iaf_pkg::ADDR_OWN_ADDR, 32'hff, 32'h0, "own address reset");
        rd(iaf_pkg::ADDR_RX_DATA, 32'hff, 32'hff, "rx data reset");
        rd(8'h1c, 32'hffffffff, 32'h0, "unmapped");
        $display("test reset done");
        bus(1'b1, iaf_pkg::ADDR_OWN_ADDR, 32'h54);
        bus(1'b1, iaf_pkg::ADDR_IRQ_EN, 32'hf);
        bus(1'b1, iaf_pkg::ADDR_CTRL, 32'h0);
        u_bus.start();
        u_bus.bits(8'h56);
        settle();
        rd(iaf_pkg::ADDR_STATUS, 32'h7, 32'h0, "foreign address");
        u_bus.start();
        u_bus.bits(8'h54);
        settle();
        flow(3'h2, "address");
        bus(1'b1, iaf_pkg::ADDR_IRQ_EN, 32'h0);
        u_bus.start();
        u_bus.bits(8'h00);
        settle();
        chk("masked irq", 32'h0, {31'h0, irq});
        bus(1'b1, iaf_pkg::ADDR_IRQ_EN, 32'hf);
        flow(3'h3, "general call");
        bus(1'b1, iaf_pkg::ADDR_CTRL, 32'h3);
        sda_drive <= 1'b1;
        u_bus.start();
        settle();
        flow(3'h4, "start lost");
        u_bus.bits(8'h00);
        settle();
        flow(3'h4, "data lost");
        sda_drive <= 1'b0;
        bus(1'b1, iaf_pkg::ADDR_CTRL, 32'h0);
        bus(1'b0, iaf_pkg::ADDR_RX_DATA, 32'h0);
        bus(1'b1, iaf_pkg::ADDR_OWN_ADDR, 32'h55);
        u_bus.bits(8'h00);
        settle();
        rd(iaf_pkg::ADDR_STATUS, 32'h27, 32'h20, "rx full");
        rd(iaf_pkg::ADDR_IRQ_STAT, 32'hf, 32'h8, "irq status");
        u_bus.bits(8'h00);
        settle();
        flow(3'h4, "overrun");
        clk_en <= 1'b0;
        u_bus.bits(8'h00);
        settle();
        clk_en <= 1'b1;
        rd(iaf_pkg::ADDR_STATUS, 32'h27, 32'h0, "frozen frame");
        u_bus.bits(8'h00);
        settle();
        rd(iaf_pkg::ADDR_STATUS, 32'h27, 32'h20, "rx full again");
        $display("test freeze done");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(iaf_pkg::ADDR_STATUS, 32'hff, 32'h0, "status after reset");
        rd(iaf_pkg::ADDR_OWN_ADDR, 32'hff, 32'h0, "own address after reset");
        chk("irq after reset", 32'h0, {31'h0, irq});
        $display("test reset again done");
        results();
    end
endmodule
